/* File: bench/amac_apu_properties.sv */
`timescale 1ns/1ps
// =====
// Port checks
module amac_apu_properties
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic [1:0] acc_src_area,
  input wire logic [1:0] acc_dst_area,
  input wire logic acc_grant,
  input wire logic acc_deny,
  input wire logic violation,
  input wire logic cfg_valid,
  input wire logic cfg_priv,
  input wire logic cfg_ack,
  input wire logic cfg_reject,
  input wire logic locked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ANS: assert property (acc_valid |=> acc_grant ^ acc_deny) else $error("answer");
  AST_IDLE: assert property (!acc_valid |=> !acc_grant && !acc_deny) else $error("stray");
  AST_AREA: assert property (acc_valid && &acc_dst_area |=> acc_deny) else $error("area");
  AST_SRC: assert property (acc_valid && &acc_src_area |=> acc_deny) else $error("source area");
  AST_VIOL: assert property (violation == acc_deny) else $error("violation");
  AST_USER: assert property (cfg_valid && !cfg_priv |=> cfg_reject) else $error("user");
  AST_CFG: assert property (cfg_valid |=> cfg_ack ^ cfg_reject) else $error("cfg");
  AST_LOCK: assert property (locked |=> locked) else $error("lock");
  AST_HOLD: assert property (cfg_valid && locked |=> cfg_reject) else $error("held");
endmodule
bind amac_area_protection_unit amac_apu_properties u_chk (.*);

/* File: bench/amac_core_model.sv */
`timescale 1ns/1ps
// =====
// Core side; released fields go inverted so stale values never pass
module amac_core_model
(
  input wire logic ref_clk,
  input wire logic acc_grant,
  input wire logic acc_deny,
  output logic acc_valid,
  output logic acc_priv,
  output logic [1:0] acc_src_area,
  output logic [1:0] acc_dst_area,
  output logic [1:0] acc_op
);
  initial {acc_valid, acc_priv, acc_src_area, acc_dst_area, acc_op} = 8'h0;
  task automatic go(logic [6:0] a, output logic [1:0] r);
    @(posedge ref_clk);
    {acc_valid, acc_priv, acc_src_area, acc_dst_area, acc_op} <= {1'h1, a};
    @(posedge ref_clk);
    {acc_valid, acc_priv, acc_src_area, acc_dst_area, acc_op} <= {1'h0, ~a};
    #1 r = {acc_grant, acc_deny};
  endtask
endmodule

/* File: bench/tb_amac_area_protection_unit.sv */
`timescale 1ns/1ps
// =====
// Bench
module tb_amac_area_protection_unit;
  logic ref_clk = 0, rst = 1, mfg_attr_valid, cfg_valid, cfg_priv, cfg_value, acc_valid, acc_priv;
  logic acc_grant, acc_deny, violation, cfg_ack, cfg_reject, locked;
  logic [1:0] cfg_cmd, acc_src_area, acc_dst_area, acc_op;
  logic [6:0] cfg_index;
  logic [71:0] mfg_attr, tbl, dfl;
  int num_errors = 0, checks_done = 0, cyc = 0;
  amac_core_model u_core (.*);
  amac_area_protection_unit u_dut (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 3000) begin num_errors++; close_out(); end
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED =="); else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [1:0] e, g);
    checks_done++;
    if (g !== e) begin num_errors++; $display("unexpected %s %b %b", n, e, g); end
  endtask
  task automatic sweep();
    logic [1:0] r, e;
    for (int i = 0; i < 128; i++)
    begin
      u_core.go(i[6:0], r);
      e = i[3:2] < 3 && i[5:4] < 3 && tbl[(i[6] ? 0 : 36) + i[5:4] * 12 + i[3:2] * 4 + i[1:0]] ? 2'h2 : 2'h1;
      chk("access", e, r);
      chk("violation", {1'b0, e[0]}, {1'b0, violation});
    end
  endtask
  task automatic boot(logic v, logic [71:0] img);
    @(posedge ref_clk);
    {rst, mfg_attr_valid, mfg_attr} <= {1'h1, v, img};
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    repeat (2) @(posedge ref_clk);
    tbl = v ? img : amac_pkg::ATTR_RESET;
    dfl = tbl;
    sweep();
  endtask
  task automatic cfg(logic [1:0] c, logic p, logic [6:0] x, logic [1:0] e);
    @(posedge ref_clk);
    {cfg_valid, cfg_priv, cfg_cmd, cfg_index, cfg_value} <= {1'h1, p, c, x, ~tbl[x]};
    @(posedge ref_clk);
    cfg_valid <= 0;
    #1 chk("cfg", e, {cfg_ack, cfg_reject});
    if (e[1] && c == 2'h0) tbl[x] = ~tbl[x];
    if (e[1] && c == 2'h1) dfl = tbl;
    if (e[1] && c == 2'h3) tbl = dfl;
  endtask
  task automatic t_manage();
    cfg(0, 1, 7'h24, 2'h2);
    cfg(1, 1, 7'h00, 2'h2);
    cfg(0, 1, 7'h30, 2'h2);
    cfg(3, 0, 7'h00, 2'h1);
    cfg(3, 1, 7'h00, 2'h2);
    cfg(0, 0, 7'h05, 2'h1);
    cfg(2, 0, 7'h00, 2'h1);
    cfg(2, 1, 7'h00, 2'h2);
    cfg(0, 1, 7'h06, 2'h1);
    sweep();
  endtask
  initial
  begin
    {cfg_valid, cfg_priv, cfg_value, cfg_cmd, cfg_index} = 12'h0;
    boot(0, 72'h0);
    boot(1, 72'ha5c396f00f693c5ae1);
    t_manage();
    close_out();
  end
endmodule

/* File: rtl/amac_area_protection_unit.sv */
// Function
// - Police read, write, delete and execute per privileged or user mode.
// - Only privileged software may define, change or lock rules; user attempts rejected.
// - Every access is from privileged or user code; policy covers both.
// - ROM, RAM and flash targets are protected objects.
// - Decision uses source area, target area and operation.
// - Decision formed before access completes; denied access gets no effect.
// - Attributes evaluated per access in hardware; grant enables, deny blocks.
// - No overriding grant or deny outside the attribute check.
// - After reset attributes hold fixed well-defined defaults.
// - Loaded alternative initial values replace the defaults.
// - Changing defaults or attributes succeeds only in privileged mode.
// - Attributes come from manufacturing input or run-time configuration.
// - Configuration held as control registers written by management software.
`timescale 1ns/1ps
module amac_area_protection_unit
(
  input wire logic ref_clk,
  input wire logic rst,
  // Access request from the core
  input wire logic acc_valid,
  input wire logic acc_priv,
  input wire logic [1:0] acc_src_area,
  input wire logic [1:0] acc_dst_area,
  input wire logic [1:0] acc_op,
  output logic acc_grant,
  output logic acc_deny,
  output logic violation,
  // Manufacturing defaults
  input wire logic [amac_pkg::ATTR_BITS-1:0] mfg_attr,
  input wire logic mfg_attr_valid,
  // Management port
  input wire logic cfg_valid,
  input wire logic cfg_priv,
  input wire logic [1:0] cfg_cmd,
  input wire logic [6:0] cfg_index,
  input wire logic cfg_value,
  output logic cfg_ack,
  output logic cfg_reject,
  output logic locked
);

  // ==========================================================
  // State
  typedef struct packed
  {
    // Table that every access with valid area codes is checked against
    logic [amac_pkg::ATTR_BITS-1:0] attr;
    // Copy that a restore command brings back into the table
    logic [amac_pkg::ATTR_BITS-1:0] dflt;
    // Set once the manufacturing image has had its chance
    logic mfg_taken;
    // Final acceptance of the rules; only reset clears it
    logic lock;
    // One-cycle answers to the core
    logic grant;
    logic deny;
    logic viol;
    // One-cycle answers to the management port
    logic ack;
    logic rej;
  } amac_state_type;

  amac_state_type st;
  amac_state_type next_st;

  // ==========================================================
  // Attribute table lookup
  // The table is one flat vector: the privileged half sits at the
  // bottom, the user half above it. Inside a half the source area
  // selects a block of target areas, and each target holds one bit
  // per operation. A set bit allows the access, a clear bit denies it.
  function automatic logic [6:0] amac_index
  (
    input logic priv,
    input logic [1:0] src,
    input logic [1:0] dst,
    input logic [1:0] op
  );
    logic [6:0] base;
    logic [6:0] src_part;
    logic [6:0] dst_part;
    logic [6:0] op_part;
    if (priv)
    begin
      base = 7'h00;
    end
    else
    begin
      base = 7'(amac_pkg::NUM_AREAS * amac_pkg::NUM_AREAS * 4);
    end
    src_part = 7'(int'(src) * amac_pkg::NUM_AREAS * 4);
    dst_part = 7'(int'(dst) * 4);
    op_part = {5'h00, op};
    return 7'(base + src_part + dst_part + op_part);
  endfunction

  function automatic logic amac_area_ok(input logic [1:0] area);
    return area != amac_pkg::AREA_NONE;
  endfunction

  // Codes outside ROM, RAM and flash own no table entry; they are refused
  // here so that a stray area code can never alias onto a real entry.
  function automatic logic amac_lookup
  (
    input logic [amac_pkg::ATTR_BITS-1:0] attr,
    input logic priv,
    input logic [1:0] src,
    input logic [1:0] dst,
    input logic [1:0] op
  );
    logic hit;
    hit = 1'b0;
    if (amac_area_ok(src) && amac_area_ok(dst))
    begin
      hit = attr[amac_index(priv, src, dst, op)];
    end
    return hit;
  endfunction

  // ==========================================================
  // Management helpers
  // A locked table refuses privileged requests too: lock is the final
  // acceptance of the rules and only reset undoes it.
  function automatic logic amac_may_manage(input logic priv, input logic lock);
    return priv && !lock;
  endfunction

  // Writes beyond the table are acknowledged but change nothing, so a
  // bad index cannot reach the stored default copy or the lock.
  function automatic logic amac_index_ok(input logic [6:0] idx);
    return idx < 7'(amac_pkg::ATTR_BITS);
  endfunction

  // ==========================================================
  // Next-state logic

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.rej = 1'b0;
    // Grant and deny are registered, so the core must hold the access until one rises.
    // Nothing else forces a grant or a deny: the table decides every access whose area codes are valid.
    if (acc_valid)
    begin
      if (amac_lookup(st.attr, acc_priv, acc_src_area, acc_dst_area, acc_op))
      begin
        next_st.grant = 1'b1;
        next_st.deny = 1'b0;
        next_st.viol = 1'b0;
      end
      else
      begin
        next_st.grant = 1'b0;
        next_st.deny = 1'b1;
        next_st.viol = 1'b1;
      end
    end
    else
    begin
      next_st.grant = 1'b0;
      next_st.deny = 1'b0;
      next_st.viol = 1'b0;
    end
    // Manufacturing values are captured once after reset release.
    // A management request in that same cycle still wins, being applied later.
    if (!st.mfg_taken)
    begin
      next_st.mfg_taken = 1'b1;
      if (mfg_attr_valid)
      begin
        next_st.dflt = mfg_attr;
        next_st.attr = mfg_attr;
      end
    end
    if (cfg_valid)
    begin
      if (!amac_may_manage(cfg_priv, st.lock))
      begin
        next_st.rej = 1'b1;
      end
      else
      begin
        next_st.ack = 1'b1;
        unique case (cfg_cmd)
          amac_pkg::CMD_WRITE:
          begin
            if (amac_index_ok(cfg_index))
            begin
              next_st.attr[cfg_index] = cfg_value;
            end
          end
          amac_pkg::CMD_LOAD_DEFAULT:
          begin
            next_st.dflt = st.attr;
          end
          amac_pkg::CMD_LOCK:
          begin
            next_st.lock = 1'b1;
          end
          amac_pkg::CMD_RESTORE:
          begin
            next_st.attr = st.dflt;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st.attr <= amac_pkg::ATTR_RESET;
      st.dflt <= amac_pkg::ATTR_RESET;
      st.mfg_taken <= 1'b0;
      st.lock <= 1'b0;
      st.grant <= 1'b0;
      st.deny <= 1'b0;
      st.viol <= 1'b0;
      st.ack <= 1'b0;
      st.rej <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign acc_grant = st.grant;
  assign acc_deny = st.deny;
  assign violation = st.viol;
  assign cfg_ack = st.ack;
  assign cfg_reject = st.rej;
  assign locked = st.lock;

endmodule

/* File: rtl/amac_pkg.sv */
package amac_pkg;
  // Memory areas
  localparam logic [1:0] AREA_ROM = 2'h0;
  localparam logic [1:0] AREA_RAM = 2'h1;
  localparam logic [1:0] AREA_FLASH = 2'h2;
  localparam logic [1:0] AREA_NONE = 2'h3;
  localparam int NUM_AREAS = 3;
  // Operations
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_DELETE = 2'h2;
  localparam logic [1:0] OP_EXEC = 2'h3;
  // Attribute table: one bit per (mode, source area, target area, op)
  localparam int ATTR_BITS = 2 * NUM_AREAS * NUM_AREAS * 4;
  // Management command codes
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_LOAD_DEFAULT = 2'h1;
  localparam logic [1:0] CMD_LOCK = 2'h2;
  localparam logic [1:0] CMD_RESTORE = 2'h3;
  // Restrictive baseline: privileged code may do anything, user code may touch RAM only
  localparam logic [ATTR_BITS-1:0] ATTR_RESET = 72'h0f00f00f0fffffffff;
endpackage
